// file: rtl/prog_crc_cfg.svh
// Offsets, reset values and sizes for the program-memory checksum block
`ifndef PROG_CRC_CFG_SVH
`define PROG_CRC_CFG_SVH
`define CKS_BYTE_ZERO_OFS   8'ha9
`define CKS_BYTE_ONE_OFS    8'haa
`define CKS_BYTE_TWO_OFS    8'hab
`define CKS_BYTE_THREE_OFS  8'hac
`define CKS_BYTE_RESET      8'h00
`define CKS_UNMAPPED_READ   8'h00
`define CKS_FULL_START      16'h0000
`define CKS_BLOCK_LOW_BYTE  8'h00
`define CKS_BLOCK_BYTES     17'h00100
`define CKS_MEM_BYTES       65536
`define CKS_POLY32          32'h04c11db7
`define CKS_POLY16          16'h1021
`endif

// file: rtl/prog_crc_pkg.sv
// Types shared by the program-memory checksum block
package prog_crc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DRAIN} cks_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

  typedef struct packed {
    logic data_out;
    logic data_oe;
  } pin_drive_type;
endpackage

// file: rtl/crc_accum.sv
// Byte-serial checksum accumulator with clear and enable
`timescale 1ns/100ps
module crc_accum #(
  parameter int              WIDTH = 32,
  parameter logic [WIDTH-1:0] POLY = '1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Control and data
  input  wire logic             clear,
  input  wire logic             en,
  input  wire logic [7:0]       data,
  // Result
  output logic      [WIDTH-1:0] crc_r
);
  logic [WIDTH-1:0] crc_nxt;

  function automatic logic [WIDTH-1:0] step(input logic [WIDTH-1:0] c, input logic [7:0] d);
    logic [WIDTH-1:0] v;
    v = c ^ {d, {(WIDTH-8){1'b0}}};
    for (int i = 0; i < 8; i++) begin
      v = v[WIDTH-1] ? ((v << 1) ^ POLY) : (v << 1);
    end
    return v;
  endfunction

  assign crc_nxt = clear ? '0 : (en ? step(crc_r, data) : crc_r);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) crc_r <= '0;
    else        crc_r <= crc_nxt;
  end
endmodule // crc_accum

// file: rtl/prog_crc.sv
// Program-memory checksum registers and engine behind the two-wire debug link
`include "prog_crc_cfg.svh"
`timescale 1ns/100ps
module prog_crc #(
  parameter int ADDR_W    = 16,
  parameter int MEM_BYTES = `CKS_MEM_BYTES
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  // Halt state of the device
  input  wire logic                      halted,
  // Register port from the link
  input  wire prog_crc_pkg::reg_req_type reg_req,
  output logic [7:0]                     reg_rdata,
  output logic                           reg_rvalid,
  // Program memory read port, data one cycle after mem_rd
  output logic [ADDR_W-1:0]              mem_addr,
  output logic                           mem_rd,
  input  wire logic [7:0]                mem_rdata,
  // Status
  output logic                           crc_busy,
  // Shared pins
  input  wire logic                      rst_pin_n,
  input  wire logic                      data_pin_in,
  output logic                           data_pin_out,
  output logic                           data_pin_oe,
  // User side of shared pins
  input  wire prog_crc_pkg::pin_drive_type user_drive,
  output logic                           core_reset_n,
  output logic                           user_data_in,
  // Link side of shared pins
  input  wire prog_crc_pkg::pin_drive_type link_drive,
  output logic                           debug_clock_pin,
  output logic                           debug_data_pin
);
  import prog_crc_pkg::*;

  localparam int CNT_W = ADDR_W + 1;

  cks_state_type     state_r, state_nxt;
  logic [31:0]       result_r, result_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [CNT_W-1:0]  left_r, left_nxt;
  logic              full_mode_r, full_mode_nxt;
  logic              rd_pend_r;
  logic [31:0]       crc32;
  logic [15:0]       crc16;

  // Byte register decode, shared by read and write paths
  function automatic logic [2:0] byte_sel(input logic [7:0] a);
    case (a)
      `CKS_BYTE_ZERO_OFS:  byte_sel = 3'h4;
      `CKS_BYTE_ONE_OFS:   byte_sel = 3'h5;
      `CKS_BYTE_TWO_OFS:   byte_sel = 3'h6;
      `CKS_BYTE_THREE_OFS: byte_sel = 3'h7;
      default:             byte_sel = 3'h0;
    endcase
  endfunction

  wire [2:0] wr_sel      = byte_sel(reg_req.addr);
  wire       idle        = (state_r == ST_IDLE);
  wire       wr_ok       = reg_req.wr && halted && idle && wr_sel[2];
  wire       start_full  = wr_ok && (wr_sel[1:0] == 2'h1);
  wire       start_block = wr_ok && (wr_sel[1:0] == 2'h0);
  wire       drained     = !mem_rd && !rd_pend_r;
  wire [7:0] rd_byte     = wr_sel[2] ? result_r[8*wr_sel[1:0] +: 8] : `CKS_UNMAPPED_READ;
  wire       start       = start_full || start_block;

  always_comb begin
    state_nxt     = state_r;
    result_nxt    = result_r;
    addr_nxt      = addr_r;
    left_nxt      = left_r;
    full_mode_nxt = full_mode_r;
    case (state_r)
      ST_IDLE: begin
        if (wr_ok) begin
          result_nxt[8*wr_sel[1:0] +: 8] = reg_req.wdata;
        end
        if (start_full) begin
          addr_nxt      = `CKS_FULL_START;
          left_nxt      = CNT_W'(MEM_BYTES);
          full_mode_nxt = 1'b1;
          state_nxt     = ST_FETCH;
        end else if (start_block) begin
          addr_nxt      = ADDR_W'({reg_req.wdata, `CKS_BLOCK_LOW_BYTE});
          left_nxt      = CNT_W'(`CKS_BLOCK_BYTES);
          full_mode_nxt = 1'b0;
          state_nxt     = ST_FETCH;
        end
      end
      ST_FETCH: begin
        addr_nxt = addr_r + 1'b1;
        left_nxt = left_r - 1'b1;
        if (left_r == CNT_W'(1)) state_nxt = ST_DRAIN;
      end
      ST_DRAIN: begin
        if (drained) begin
          // Results take the checksum only here, once the last byte has been folded in
          if (full_mode_r) result_nxt = crc32;
          else             result_nxt = {result_r[31:16], crc16};
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r     <= ST_IDLE;
      result_r    <= {4{`CKS_BYTE_RESET}};
      addr_r      <= '0;
      left_r      <= '0;
      full_mode_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      result_r    <= result_nxt;
      addr_r      <= addr_nxt;
      left_r      <= left_nxt;
      full_mode_r <= full_mode_nxt;
    end
  end

  // Memory fetch pipeline and register reads
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mem_rd     <= 1'b0;
      mem_addr   <= '0;
      rd_pend_r  <= 1'b0;
      crc_busy   <= 1'b0;
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      mem_rd     <= (state_r == ST_FETCH);
      mem_addr   <= addr_r;
      rd_pend_r  <= mem_rd;
      crc_busy   <= (state_nxt != ST_IDLE);
      reg_rdata  <= rd_byte;
      reg_rvalid <= reg_req.rd && halted;
    end
  end

  // Pin sharing: while halted the link owns the reset and data pins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      core_reset_n    <= 1'b0;
      user_data_in    <= 1'b0;
      debug_clock_pin <= 1'b1;
      debug_data_pin  <= 1'b0;
      data_pin_out    <= 1'b0;
      data_pin_oe     <= 1'b0;
    end else begin
      core_reset_n    <= halted ? 1'b1 : rst_pin_n;
      user_data_in    <= halted ? user_data_in : data_pin_in;
      debug_clock_pin <= halted ? rst_pin_n : 1'b1;
      debug_data_pin  <= halted ? data_pin_in : 1'b0;
      data_pin_out    <= halted ? link_drive.data_out : user_drive.data_out;
      data_pin_oe     <= halted ? link_drive.data_oe : user_drive.data_oe;
    end
  end

  crc_accum #(.WIDTH(32), .POLY(`CKS_POLY32)) u_crc32 (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clear   (start),
    .en      (rd_pend_r && full_mode_r),
    .data    (mem_rdata),
    .crc_r   (crc32)
  );

  crc_accum #(.WIDTH(16), .POLY(`CKS_POLY16)) u_crc16 (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clear   (start),
    .en      (rd_pend_r && !full_mode_r),
    .data    (mem_rdata),
    .crc_r   (crc16)
  );
endmodule // prog_crc

// file: tb/prog_crc_chk.sv
// Port assertions for the program-memory checksum block
`timescale 1ns/100ps
module prog_crc_chk (
  // Clock, reset and state
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        halted,
  // Register port, engine and pins
  input wire prog_crc_pkg::reg_req_type reg_req,
  input wire logic        reg_rvalid,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        crc_busy,
  input wire logic        rst_pin_n,
  input wire logic        data_pin_in,
  input wire logic        debug_clock_pin,
  input wire logic        debug_data_pin,
  // Shared pin drive and user side
  input wire prog_crc_pkg::pin_drive_type user_drive,
  input wire prog_crc_pkg::pin_drive_type link_drive,
  input wire logic        data_pin_out,
  input wire logic        data_pin_oe,
  input wire logic        core_reset_n,
  input wire logic        user_data_in
);
  wire       go = reg_req.wr & halted & !crc_busy;
  wire [7:0] ad = reg_req.addr;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_full_start: assert property (go && ad == 8'haa |=>
    crc_busy ##1 mem_rd && mem_addr == 16'h0000) else $error("bad full start");
  chk_block_start: assert property (go && ad == 8'ha9 |-> ##2 mem_rd &&
    mem_addr == {$past(reg_req.wdata, 2), 8'h00}) else $error("bad block start");
  chk_busy_end: assert property ($fell(mem_rd) |-> crc_busy [*2] ##1 !crc_busy)
    else $error("bad busy end");
  chk_fetch_busy: assert property (mem_rd |-> crc_busy) else $error("fetch idle");
  chk_read_reply: assert property (reg_req.rd && halted |=> reg_rvalid)
    else $error("no reply");
  chk_read_off: assert property (reg_req.rd && !halted |=> !reg_rvalid)
    else $error("reply running");
  chk_pin_route: assert property (halted |=> debug_clock_pin == $past(rst_pin_n) &&
    debug_data_pin == $past(data_pin_in)) else $error("pins not routed");
  chk_pin_idle: assert property (!halted |=> debug_clock_pin && !debug_data_pin)
    else $error("pins not idle");
  chk_link_drive: assert property (halted |=>
    data_pin_out == $past(link_drive.data_out) && data_pin_oe == $past(link_drive.data_oe))
    else $error("link drive lost");
  chk_user_drive: assert property (!halted |=>
    data_pin_out == $past(user_drive.data_out) && data_pin_oe == $past(user_drive.data_oe))
    else $error("user drive lost");
  chk_core_reset: assert property (halted |=> core_reset_n)
    else $error("core reset leaked");
  chk_user_freeze: assert property (halted |=> $stable(user_data_in))
    else $error("user input moved");
endmodule // prog_crc_chk
bind prog_crc prog_crc_chk chk (.sys_clk, .rst_n, .halted, .reg_req, .reg_rvalid, .mem_addr,
  .mem_rd, .crc_busy, .rst_pin_n, .data_pin_in, .debug_clock_pin, .debug_data_pin,
  .user_drive, .link_drive, .data_pin_out, .data_pin_oe, .core_reset_n, .user_data_in);

// file: tb/debug_host.sv
// Debug adapter model driving the register port
`timescale 1ns/100ps
module debug_host (
  // Clock and register port
  input  wire logic                 sys_clk,
  output prog_crc_pkg::reg_req_type reg_req,
  input  wire logic [7:0]           reg_rdata,
  input  wire logic                 reg_rvalid
);
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, d);
    @(negedge sys_clk) reg_req <= {a, d, 2'b10};
    @(negedge sys_clk) reg_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic v);
    @(negedge sys_clk) reg_req <= {a, 8'h00, 2'b01};
    @(negedge sys_clk) v = reg_rvalid;
    q = reg_rdata;
    reg_req <= '0;
  endtask
endmodule // debug_host

// file: tb/debug_port_program_memory_crc_test.sv
// Bench for the program-memory checksum block
`timescale 1ns/100ps
`include "prog_crc_cfg.svh"
module debug_port_program_memory_crc_test;
  logic sys_clk = 1'b0, rst_n = 1'b0, halted = 1'b1, rst_pin_n = 1'b1;
  logic data_pin_in = 1'b0, reg_rvalid, mem_rd, crc_busy, v;
  logic [7:0] mem_rdata = 8'h00, reg_rdata, q;
  logic [15:0] mem_addr;
  logic [31:0] res;
  logic ext_rst_n = 1'b1, core_reset_n, user_data_in, data_pin_out, data_pin_oe;
  logic debug_clock_pin, debug_data_pin;
  wire [5:0] pins = {core_reset_n, user_data_in, data_pin_out, data_pin_oe, debug_clock_pin,
    debug_data_pin};
  prog_crc_pkg::reg_req_type reg_req;
  prog_crc_pkg::pin_drive_type user_drive = 2'b00, link_drive = 2'b00;
  int fails = 0, n_tests = 0;
  always #2 sys_clk = ~sys_clk;
  prog_crc #(.MEM_BYTES(512)) uut (.sys_clk, .rst_n, .halted, .reg_req, .reg_rdata,
    .reg_rvalid, .mem_addr, .mem_rd, .mem_rdata, .crc_busy, .rst_pin_n, .data_pin_in,
    .data_pin_out, .data_pin_oe, .user_drive, .core_reset_n,
    .user_data_in, .link_drive, .debug_clock_pin, .debug_data_pin);
  debug_host host (.sys_clk, .reg_req, .reg_rdata, .reg_rvalid);
  function automatic logic [7:0] mv(logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  // Link clock on the reset pin only while halted; memory garbles when not read
  always @(negedge sys_clk) rst_pin_n <= halted ? !rst_pin_n : ext_rst_n;
  always @(negedge sys_clk) data_pin_in <= !data_pin_in;
  always @(posedge sys_clk) mem_rdata <= mem_rd ? mv(mem_addr) : ~mem_rdata;
  function automatic logic [31:0] crc(int t, logic [15:0] s, int n, logic [31:0] p);
    logic [31:0] c = 32'h0;
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = mv(s + 16'(i));
      for (int k = 7; k >= 0; k--) c = (c << 1) ^ (c[t] ^ b[k] ? p : 32'h0);
    end
    return c;
  endfunction
  task automatic ck(input logic [8:0] g, e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rd_all;
    for (int i = 0; i < 4; i++) begin
      host.rd(8'ha9 + 8'(i), q, v);
      ck({v, q}, {1'b1, res[8*i +: 8]});
    end
  endtask
  task automatic start(input logic [7:0] a, d);
    host.wr(a, d);
    for (int i = 0; i < 999 && crc_busy !== 1'b0; i++) @(negedge sys_clk);
    ck({crc_busy, 8'h00}, 9'h000);
  endtask
  task automatic t_reset;
    res = 32'h0;
    rd_all();
    host.rd(8'hb0, q, v);
    ck({v, q}, 9'h100);
    $display("t_reset done");
  endtask
  task automatic t_full;
    host.wr(8'haa, 8'h5c);
    host.rd(8'hac, q, v);
    ck({v, q}, 9'h100);
    start(8'ha9, 8'h33);
    res = crc(31, 16'h0000, 512, `CKS_POLY32);
    rd_all();
    $display("t_full done");
  endtask
  task automatic t_block;
    start(8'ha9, 8'hff);
    res[15:0] = 16'(crc(15, 16'hff00, 256, 32'(`CKS_POLY16)));
    rd_all();
    $display("t_block done");
  endtask
  task automatic t_halt;
    @(negedge sys_clk) halted = 1'b0;
    host.rd(8'ha9, q, v);
    host.wr(8'haa, 8'h11);
    ck({v, crc_busy, 7'h00}, 9'h000);
    @(negedge sys_clk) halted = 1'b1;
    rd_all();
    $display("t_halt done");
  endtask
  // User input follows the data pin only while running; it stays put once halted
  task automatic t_pins;
    logic frz;
    @(negedge sys_clk) halted = 1'b0;
    user_drive = 2'b10;
    link_drive = 2'b01;
    ext_rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    ck({3'h0, pins}, {3'h0, 1'b0, data_pin_in, 4'ha});
    ext_rst_n = 1'b1;
    @(negedge sys_clk) halted = 1'b1;
    frz = user_data_in;
    repeat (2) @(negedge sys_clk);
    ck({3'h0, pins}, {3'h0, 1'b1, frz, 2'b01, rst_pin_n, data_pin_in});
    $display("t_pins done");
  endtask
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20 rst_n = 1'b1;
    t_reset();
    t_full();
    t_block();
    t_halt();
    t_pins();
    close_out();
  end
  // Whole run needs about 830 cycles
  initial begin
    #20000 fails++;
    close_out();
  end
endmodule // debug_port_program_memory_crc_test
